// [verilog/stepper_step_dir_translator.sv]
// Behaviour
// - one step per rising step edge only
// - step size follows resolution selector
// - direction high clockwise, low counterclockwise
// - windings off forces zero current
// - direction and windings off act within 25 us
// - overcurrent lights fault indicator
// - fault latched until presetn reset
// - half step gives half rotation
// - selector 8 off full, on half
// - highest selected current level wins
`timescale 1ns/1ns
module stepper_step_dir_translator (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic step_in,
  input wire logic dir_in,
  input wire logic windings_off_n,
  input wire logic [7:0] selector,
  input wire logic overcurrent,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output step_pkg::winding_t winding,
  output logic fault_led,
  output logic irq
);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic [2:0] top_level(input logic [6:0] sw);
    logic [2:0] lv;
    lv = step_pkg::LEVEL_OFF;
    for (int i = 0; i < step_pkg::CUR_SW_W; i++)
    begin
      if (sw[i])
      begin
        lv = 3'(i + 1);
      end
    end
    return lv;
  endfunction

  // ---------------------------------------------------------------
  // input sampling and edge detect
  // ---------------------------------------------------------------
  logic step_q;
  logic step_prev_q;
  logic dir_q;
  logic off_n_q;
  wire step_rise = step_q & ~step_prev_q;
  wire half_sel = selector[step_pkg::RES_SW_BIT];
  wire [2:0] incr = half_sel ? step_pkg::STEP_HALF : step_pkg::STEP_FULL;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      step_q <= 1'b0;
      step_prev_q <= 1'b0;
    end
    else
    begin
      step_q <= step_in;
      step_prev_q <= step_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dir_q <= 1'b0;
      off_n_q <= 1'b0;
    end
    else
    begin
      dir_q <= dir_in;
      off_n_q <= windings_off_n;
    end
  end

  // ---------------------------------------------------------------
  // phase sequencer
  // ---------------------------------------------------------------
  logic [2:0] phase_q;
  logic [2:0] phase_d;
  logic [15:0] pos_q;
  logic [15:0] pos_d;

  assign phase_d = !step_rise ? phase_q : (dir_q ? phase_q + incr : phase_q - incr);
  assign pos_d = !step_rise ? pos_q : (dir_q ? pos_q + 16'h0001 : pos_q - 16'h0001);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_q <= step_pkg::PHASE_RST;
    end
    else
    begin
      phase_q <= phase_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pos_q <= step_pkg::POS_RST;
    end
    else
    begin
      pos_q <= pos_d;
    end
  end

  // ---------------------------------------------------------------
  // winding drive
  // ---------------------------------------------------------------
  step_pkg::winding_t wind_d;
  logic fault_q;
  wire fault_d = fault_q | overcurrent;
  wire [2:0] level_sel = top_level(selector[step_pkg::CUR_SW_W-1:0]);
  wire drive_on = off_n_q & ~fault_q;

  // even index drives both windings, odd index drives one
  always_comb
  begin
    wind_d = step_pkg::WIND_RST;
    case (phase_q)
      3'h0: wind_d = '{1'b1, 1'b1, 1'b1, 1'b1, level_sel};
      3'h1: wind_d = '{1'b0, 1'b0, 1'b1, 1'b1, level_sel};
      3'h2: wind_d = '{1'b1, 1'b0, 1'b1, 1'b1, level_sel};
      3'h3: wind_d = '{1'b1, 1'b0, 1'b0, 1'b0, level_sel};
      3'h4: wind_d = '{1'b1, 1'b0, 1'b1, 1'b0, level_sel};
      3'h5: wind_d = '{1'b0, 1'b0, 1'b1, 1'b0, level_sel};
      3'h6: wind_d = '{1'b1, 1'b1, 1'b1, 1'b0, level_sel};
      3'h7: wind_d = '{1'b1, 1'b1, 1'b0, 1'b0, level_sel};
      default: wind_d = step_pkg::WIND_RST;
    endcase
    if (!drive_on)
    begin
      wind_d = step_pkg::WIND_RST;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      winding <= step_pkg::WIND_RST;
    end
    else
    begin
      winding <= wind_d;
    end
  end

  // ---------------------------------------------------------------
  // fault latch
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fault_q <= 1'b0;
    end
    else
    begin
      fault_q <= fault_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fault_led <= 1'b0;
    end
    else
    begin
      fault_led <= fault_d;
    end
  end

  // ---------------------------------------------------------------
  // apb slave and interrupts
  // ---------------------------------------------------------------
  logic [1:0] irq_stat_q;
  logic [1:0] irq_stat_d;
  logic [1:0] irq_mask_q;
  logic [1:0] irq_mask_d;
  logic [31:0] rdata_d;
  logic [31:0] prdata_d;
  wire setup = psel & ~penable;
  wire access = psel & penable & pready;
  wire wr = access & pwrite;
  wire rd_setup = setup & ~pwrite;
  wire hit_stat = paddr == step_pkg::ADDR_STATUS;
  wire hit_istat = paddr == step_pkg::ADDR_IRQ_STAT;
  wire hit_imask = paddr == step_pkg::ADDR_IRQ_MASK;
  wire hit_pos = paddr == step_pkg::ADDR_POS;
  wire mapped = hit_stat | hit_istat | hit_imask | hit_pos;
  wire [1:0] events;
  wire [1:0] w1c = (wr & hit_istat) ? pwdata[1:0] : 2'h0;
  wire irq_d = |(irq_stat_d & irq_mask_q);

  assign events[step_pkg::IRQ_STEP_BIT] = step_rise;
  assign events[step_pkg::IRQ_FAULT_BIT] = overcurrent & ~fault_q;
  // set wins over write-one-clear
  assign irq_stat_d = (irq_stat_q & ~w1c) | events;
  assign irq_mask_d = (wr & hit_imask) ? pwdata[1:0] : irq_mask_q;
  assign prdata_d = rd_setup ? rdata_d : prdata;
  assign rdata_d = hit_stat ? {24'h000000, selector[7:5], fault_q, off_n_q, dir_q, phase_q[1:0]}
    : hit_istat ? {30'h00000000, irq_stat_q}
    : hit_imask ? {30'h00000000, irq_mask_q}
    : hit_pos ? {16'h0000, pos_q}
    : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat_q <= step_pkg::IRQ_RST;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_mask_q <= step_pkg::IRQ_RST;
    end
    else
    begin
      irq_mask_q <= irq_mask_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= irq_d;
    end
  end

  // ---------------------------------------------------------------
  // apb handshake
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
    end
    else
    begin
      pready <= setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pslverr <= 1'b0;
    end
    else
    begin
      pslverr <= setup & ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
    end
    else
    begin
      prdata <= prdata_d;
    end
  end

endmodule

// [verilog/step_pkg.sv]
package step_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned RESPONSE_US = 25;
  localparam int unsigned RESPONSE_CYC = (RESPONSE_US * CLK_HZ) / 1000000;
  localparam int unsigned MAX_STEP_HZ = 20000;
  localparam int unsigned MIN_PULSE_US = 25;

  // ---------------------------------------------------------------
  // selector layout
  // ---------------------------------------------------------------
  localparam int unsigned CUR_SW_W = 7;
  localparam int unsigned SEL_W = 8;
  localparam int unsigned RES_SW_BIT = 7;
  localparam int unsigned LEVEL_W = 3;
  localparam int unsigned FULL_PPR = 200;
  localparam int unsigned HALF_PPR = 400;

  // ---------------------------------------------------------------
  // phase sequence
  // ---------------------------------------------------------------
  localparam int unsigned PHASE_W = 3;
  localparam logic [2:0] PHASE_RST = 3'h0;
  localparam logic [2:0] STEP_FULL = 3'h2;
  localparam logic [2:0] STEP_HALF = 3'h1;
  localparam logic [2:0] LEVEL_OFF = 3'h0;

  // ---------------------------------------------------------------
  // apb register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
  localparam logic [7:0] ADDR_POS = 8'h0C;
  localparam logic [1:0] IRQ_RST = 2'h0;
  localparam int unsigned IRQ_STEP_BIT = 0;
  localparam int unsigned IRQ_FAULT_BIT = 1;
  localparam logic [15:0] POS_RST = 16'h0000;

  // ---------------------------------------------------------------
  // winding drive carrier
  // ---------------------------------------------------------------
  typedef struct packed {
    logic a_en;
    logic a_pos;
    logic b_en;
    logic b_pos;
    logic [2:0] level;
  } winding_t;

  localparam winding_t WIND_RST = '{default: 1'b0};

endpackage

// [verification/step_ctrl_model.sv]
`timescale 1ns/1ns
module step_ctrl_model (
  input wire logic pclk,
  input wire logic go,
  output logic step_in,
  output logic busy
);
  localparam int PERIOD_CYC = step_pkg::CLK_HZ / step_pkg::MAX_STEP_HZ;
  localparam int HIGH_CYC = step_pkg::MIN_PULSE_US * (step_pkg::CLK_HZ / 1000000);
  int cnt = 0;
  always_ff @(posedge pclk)
    if (cnt != 0)
      cnt <= cnt - 1;
    else if (go)
      cnt <= PERIOD_CYC;
  assign step_in = cnt > PERIOD_CYC - HIGH_CYC;
  assign busy = cnt != 0;
endmodule

// [verification/stepper_checker.sv]
`timescale 1ns/1ns
module stepper_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic step_in,
  input wire logic windings_off_n,
  input wire logic [7:0] selector,
  input wire logic overcurrent,
  input wire step_pkg::winding_t winding,
  input wire logic fault_led
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [2:0] top;
  wire logic on = windings_off_n && !fault_led && !overcurrent;
  always_comb
  begin
    top = 3'h0;
    for (int i = 0; i < 7; i++)
      if (selector[i]) top = 3'(i + 1);
  end
  AST_FAULT_SET: assert property (overcurrent |=> fault_led)
    else $error("fault not lit");
  AST_FAULT_HOLD: assert property (fault_led |=> fault_led)
    else $error("fault cleared");
  AST_FAULT_ZERO: assert property (fault_led |=> winding == step_pkg::WIND_RST)
    else $error("windings on in fault");
  AST_OFF_ZERO: assert property (!windings_off_n [*3] |-> winding == step_pkg::WIND_RST)
    else $error("windings on while off");
  AST_STEP: assert property ($rose(step_in) && on |-> ##[1:4] $changed(winding))
    else $error("no step");
  AST_NO_FALL: assert property ((!step_in && on && $stable(selector)) [*5] |-> $stable(winding))
    else $error("step without rise");
  AST_LEVEL: assert property ((on && $stable(selector)) [*4] |-> winding.level == top)
    else $error("wrong level");
  AST_HALF: assert property ($rose(step_in) && selector[7] && on |->
    ##4 (winding.a_en & winding.b_en) != $past(winding.a_en & winding.b_en, 4))
    else $error("half step wrong");
endmodule
bind stepper_step_dir_translator stepper_checker i_chk (
  .pclk(pclk),
  .presetn(presetn),
  .step_in(step_in),
  .windings_off_n(windings_off_n),
  .selector(selector),
  .overcurrent(overcurrent),
  .winding(winding),
  .fault_led(fault_led)
);

// [verification/testbench.sv]
`timescale 1ns/1ns
module testbench;
  localparam int R = step_pkg::RESPONSE_CYC;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic go = 1'b0;
  logic dir_in = 1'b0;
  logic windings_off_n = 1'b1;
  logic overcurrent = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] selector = 8'h01;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, fault_led, irq, step_in, busy, slv;
  step_pkg::winding_t winding;
  logic [2:0] idx = 3'h0;
  logic [15:0] pos = 16'h0;
  int error_cnt = 0;
  int cmp_count = 0;
  always #25 pclk = ~pclk;
  step_ctrl_model i_ctrl (.pclk(pclk), .go(go), .step_in(step_in), .busy(busy));
  stepper_step_dir_translator i_dut (
    .pclk(pclk),
    .presetn(presetn),
    .step_in(step_in),
    .dir_in(dir_in),
    .windings_off_n(windings_off_n),
    .selector(selector),
    .overcurrent(overcurrent),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .winding(winding),
    .fault_led(fault_led),
    .irq(irq)
  );
  // ----
  // checking and bus tasks
  // ----
  task results();
    $display("checks %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  function automatic logic [31:0] stat(input logic f);
    return {24'h0, selector[7:5], f, windings_off_n, dir_in, idx[1:0]};
  endfunction
  function automatic logic [31:0] lvl(input logic [6:0] s);
    lvl = 32'h0;
    for (int i = 0; i < 7; i++)
      if (s[i]) lvl = i + 1;
  endfunction
  task step_once();
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    do @(posedge pclk); while (busy);
    idx = dir_in ? idx + (selector[7] ? 3'h1 : 3'h2) : idx - (selector[7] ? 3'h1 : 3'h2);
    pos = dir_in ? pos + 16'h1 : pos - 16'h1;
  endtask
  // ----
  // main sequence
  // ----
  initial
  begin
    void'($urandom(14));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rchk(step_pkg::ADDR_STATUS, stat(1'b0));
    rchk(step_pkg::ADDR_POS, 32'h0);
    rchk(step_pkg::ADDR_IRQ_MASK, 32'h0);
    for (int i = 0; i < 20; i++)
    begin
      dir_in <= 1'($urandom);
      selector <= 8'($urandom);
      repeat (R) @(posedge pclk);
      step_once();
      rchk(step_pkg::ADDR_STATUS, stat(1'b0));
      rchk(step_pkg::ADDR_POS, {16'h0, pos});
      chk(winding.a_en + winding.b_en, idx[0] ? 32'h1 : 32'h2);
      chk(winding.level, lvl(selector[6:0]));
    end
    apb(1'b1, step_pkg::ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    apb(1'b1, step_pkg::ADDR_IRQ_STAT, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    windings_off_n <= 1'b0;
    repeat (R) @(posedge pclk);
    chk(winding, 32'h0);
    rchk(step_pkg::ADDR_STATUS, stat(1'b0));
    windings_off_n <= 1'b1;
    apb(1'b0, 8'h10, 32'h0);
    chk(slv, 1'b1);
    overcurrent <= 1'b1;
    @(posedge pclk);
    overcurrent <= 1'b0;
    repeat (R) @(posedge pclk);
    chk(fault_led, 1'b1);
    chk(irq, 1'b0);
    apb(1'b1, step_pkg::ADDR_IRQ_MASK, 32'h2);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    apb(1'b1, step_pkg::ADDR_IRQ_STAT, 32'h3);
    rchk(step_pkg::ADDR_STATUS, stat(1'b1));
    chk(winding, 32'h0);
    chk(irq, 1'b0);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(fault_led, 1'b0);
    results();
  end
  initial
  begin
    #5000000;
    error_cnt++;
    results();
  end
endmodule
